// ===== pkg/vic_params.svh
/*
 * Offsets, field positions, reset values and cycle counts of the vectored
 * interrupt controller and its core-side partner.
 * Assumes inclusion by bare name from the package and both ends.
 */
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

`define VIC_NUM_VEC        32
`define VIC_NUM_LVL        8
`define VIC_ADDR_W         8
`define VIC_PC_W           16

`define VIC_OFS_ENABLE     8'h00
`define VIC_OFS_SET_PENDING_FLAG   8'h04
`define VIC_OFS_CLR_PENDING_FLAG   8'h08
`define VIC_OFS_STATUS     8'h0c
`define VIC_OFS_SRC_LO     8'h10
`define VIC_OFS_SRC_HI     8'h14
`define VIC_OFS_PRIO0      8'h20
`define VIC_OFS_PRIO_LAST  8'h2c
`define VIC_OFS_VECT0      8'h80
`define VIC_OFS_VECT_LAST  8'hfc

`define VIC_STAT_LVL_LSB   0
`define VIC_STAT_DEPTH_LSB 4
`define VIC_STAT_BUSY_BIT  8

`define VIC_RST_ENABLE     32'h0000_0000
`define VIC_RST_SRC        2'h0
`define VIC_RST_PRIO       3'h7
`define VIC_RST_VECT       16'h0000
`define VIC_IDLE_LVL       4'h8

`define VIC_FIXED_USED     32'hebff_fffb

`define VIC_EVAL_CLOCKS    3
`define VIC_ACK_CYCLES     7

`endif

// ===== pkg/vic_pkg.sv
/*
 * Types shared by the interrupt controller and its core-side partner.
 * Assumes vic_params.svh is on the include path.
 */
`include "vic_params.svh"

package vic_pkg;
    typedef logic [`VIC_NUM_VEC-1:0] vic_vec_t;
    typedef logic [4:0]              vic_num_t;
    typedef logic [2:0]              vic_prio_t;
    typedef logic [3:0]              vic_lvl_t;
    typedef logic [`VIC_PC_W-1:0]    vic_addr_t;
    typedef logic [31:0]             vic_word_t;
    typedef logic [`VIC_ADDR_W-1:0]  vic_ofs_t;

    typedef enum logic [1:0] {
        VIC_SRC_FIXED,
        VIC_SRC_DMA,
        VIC_SRC_FABRIC,
        VIC_SRC_NONE
    } vic_src_t;
endpackage

// ===== pkg/vic_if.sv
/*
 * Link between the interrupt controller and the CPU core.
 * Assumes both ends share one clock; the testbench instantiates and joins them.
 */
`timescale 1ns/1ns

interface vic_if;
    import vic_pkg::*;
    logic      irq;
    vic_num_t  irq_num;
    vic_addr_t isr_addr;
    logic      core_irq_acknowledge;
    logic      return_from_interrupt;
    logic      handler_complete;

    modport ctrl (
        output irq,
        output irq_num,
        output isr_addr,
        output handler_complete,
        input  core_irq_acknowledge,
        input  return_from_interrupt
    );

    modport cpu (
        input  irq,
        input  irq_num,
        input  isr_addr,
        input  handler_complete,
        output core_irq_acknowledge,
        output return_from_interrupt
    );
endinterface

// ===== core/vic_ctrl.sv
/*
 * Vectored interrupt controller: 32 vectors with source select, enable, priority, handler address, nesting stack.
 * Assumes requests synchronous to clk_i and a software port with read data one cycle after the strobe.
 */
// The plain strobed port and the register addresses are this design's own decisions.
// Contract
// - Thirty-two vectors, each with programmable handler address.
// - Eight run-time priorities, eight nesting levels.
// - Each vector has its own enable.
// - Software can set and clear pending.
// - Core finishes instruction, pushes PC, jumps.
// - Return instruction pops saved PC.
// - Equal priority: lower vector number wins.
// - Source per vector: fixed, DMA or fabric.
// - DMA vectors 0-15 low bus, 16-31 high.
// - Fabric source: vector n takes line n.
// - Request sets pending on next clock edge.
// - Posted flag follows pending one step later.
// - Evaluation three clocks, then request and number.
// - Present handler address; core acknowledges, reads it.
// - Acknowledge clears pending, then posted.
// - Acknowledge removed after seven cycles.
// - Return pulse restores previous active level and raises completion pulse.
`timescale 1ns/1ns
`include "vic_params.svh"

module vic_ctrl #(
    parameter logic [31:0] FIXED_USED = `VIC_FIXED_USED
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             ce_i,
    input  wire vic_pkg::vic_vec_t fixed_req_i,
    input  wire logic [15:0]      dma_term_out_low_i,
    input  wire logic [15:0]      dma_term_out_high_i,
    input  wire vic_pkg::vic_vec_t fabric_req_i,
    input  wire vic_pkg::vic_ofs_t reg_addr_i,
    input  wire vic_pkg::vic_word_t reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output vic_pkg::vic_word_t    reg_rdata_o,
    vic_if.ctrl                   link
);
    import vic_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_REQ, ST_ACK} st_t;

    vic_vec_t  enable;
    vic_vec_t  pending_flag;
    vic_vec_t  posted_flag;
    vic_vec_t  src_prev;
    vic_vec_t  src_now;
    vic_src_t  src_sel [`VIC_NUM_VEC];
    vic_prio_t prio    [`VIC_NUM_VEC];
    vic_addr_t vect    [`VIC_NUM_VEC];
    vic_lvl_t  lvl_stack [`VIC_NUM_LVL];
    vic_lvl_t  active_lvl;
    logic [3:0] depth;
    st_t       state;
    logic [1:0] eval_cnt;
    vic_num_t  win_num;
    logic      win_ok;
    vic_num_t  take_num;
    logic      irq_q;
    logic      done_q;
    vic_num_t  num_q;
    vic_addr_t addr_q;
    vic_word_t rdata;
    vic_vec_t  sw_set;
    vic_vec_t  sw_clr;
    vic_vec_t  hw_set;
    vic_vec_t  ack_clr;
    vic_vec_t  posted_flag_clr;
    logic      ack_seen;

    generate
        for (genvar v = 0; v < `VIC_NUM_VEC; v++) begin : g_src
            always_comb begin
                case (src_sel[v])
                    VIC_SRC_FIXED:  src_now[v] = fixed_req_i[v] & FIXED_USED[v];
                    VIC_SRC_DMA:    src_now[v] = (v < 16) ? dma_term_out_low_i[v % 16] : dma_term_out_high_i[v % 16];
                    VIC_SRC_FABRIC: src_now[v] = fabric_req_i[v];
                    default:        src_now[v] = 1'b0;
                endcase
            end
        end
    endgenerate

    // winner search: lowest level, then lowest vector, strictly below active.
    function automatic logic [5:0] pick(input vic_vec_t cand, input vic_lvl_t lim);
        logic [5:0] res;
        vic_lvl_t   best;
        res  = 6'h00;
        best = lim;
        for (int i = 0; i < `VIC_NUM_VEC; i++) begin
            if (cand[i] && ({1'b0, prio[i]} < best)) begin
                best = {1'b0, prio[i]};
                res  = {1'b1, i[4:0]};
            end
        end
        return res;
    endfunction

    always_comb {win_ok, win_num} = pick(posted_flag & enable, active_lvl);

    function automatic logic wr_hit(input vic_ofs_t ofs);
        return reg_wr_i && (reg_addr_i == ofs);
    endfunction

    assign hw_set   = src_now & ~src_prev;
    always_comb sw_set = wr_hit(`VIC_OFS_SET_PENDING_FLAG) ? reg_wdata_i : '0;
    always_comb sw_clr = wr_hit(`VIC_OFS_CLR_PENDING_FLAG) ? reg_wdata_i : '0;
    assign ack_seen = (state == ST_REQ) && link.core_irq_acknowledge;
    assign ack_clr  = ack_seen ? (vic_vec_t'(1) << take_num) : '0;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) src_prev <= '0;
        else if (ce_i) src_prev <= src_now;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending_flag <= '0;
        end else if (ce_i) begin
            pending_flag <= (pending_flag & ~sw_clr & ~ack_clr) | hw_set | sw_set;
        end
    end

    // posted follows pending, cleared one cycle after pending
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            posted_flag <= '0;
            posted_flag_clr    <= '0;
        end else if (ce_i) begin
            posted_flag_clr    <= ack_clr | sw_clr;
            posted_flag <= (posted_flag & ~posted_flag_clr & ~(sw_clr & ~pending_flag)) | pending_flag;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state    <= ST_IDLE;
            eval_cnt <= 2'h0;
            take_num <= 5'h00;
            irq_q    <= 1'b0;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    if (win_ok) begin
                        state    <= ST_EVAL;
                        eval_cnt <= 2'(`VIC_EVAL_CLOCKS - 1);
                    end
                end
                ST_EVAL: begin
                    if (!win_ok) begin
                        state <= ST_IDLE;
                    end else if (eval_cnt == 2'h1) begin
                        state    <= ST_REQ;
                        take_num <= win_num;
                        irq_q    <= 1'b1;
                    end
                    eval_cnt <= eval_cnt - 2'h1;
                end
                ST_REQ: begin
                    if (link.core_irq_acknowledge) begin
                        state <= ST_ACK;
                        irq_q <= 1'b0;
                    end
                end
                ST_ACK: begin
                    if (!link.core_irq_acknowledge) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // number and handler address held for the core to read
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            num_q  <= 5'h00;
            addr_q <= `VIC_RST_VECT;
        end else if (ce_i && state == ST_EVAL && eval_cnt == 2'h1) begin
            num_q  <= win_num;
            addr_q <= vect[win_num];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            active_lvl <= `VIC_IDLE_LVL;
            depth      <= 4'h0;
            done_q     <= 1'b0;
            for (int i = 0; i < `VIC_NUM_LVL; i++) lvl_stack[i] <= `VIC_IDLE_LVL;
        end else if (ce_i) begin
            done_q <= 1'b0;
            if (ack_seen && depth < 4'(`VIC_NUM_LVL)) begin
                lvl_stack[depth[2:0]] <= active_lvl;
                active_lvl            <= {1'b0, prio[take_num]};
                depth                 <= depth + 4'h1;
            end else if (link.return_from_interrupt && depth != 4'h0) begin
                active_lvl <= lvl_stack[depth[2:0] - 3'h1];
                depth      <= depth - 4'h1;
                done_q     <= 1'b1;
            end
        end
    end

    // Configuration registers; vectors are reached one word each.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable <= `VIC_RST_ENABLE;
            for (int i = 0; i < `VIC_NUM_VEC; i++) begin
                src_sel[i] <= vic_src_t'(`VIC_RST_SRC);
                prio[i]    <= `VIC_RST_PRIO;
                vect[i]    <= `VIC_RST_VECT;
            end
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == `VIC_OFS_ENABLE) enable <= reg_wdata_i;
            for (int i = 0; i < `VIC_NUM_VEC; i++) begin
                if (reg_addr_i == (i < 16 ? `VIC_OFS_SRC_LO : `VIC_OFS_SRC_HI)) begin
                    src_sel[i] <= vic_src_t'(reg_wdata_i[2*(i%16) +: 2]);
                end
                if (reg_addr_i == vic_ofs_t'(`VIC_OFS_PRIO0 + 4*(i/8))) prio[i] <= reg_wdata_i[4*(i%8) +: 3];
                if (reg_addr_i == vic_ofs_t'(`VIC_OFS_VECT0 + 4*i)) vect[i] <= reg_wdata_i[15:0];
            end
        end
    end

    always_comb begin
        rdata = '0;
        for (int i = 0; i < `VIC_NUM_VEC; i++) begin
            if (reg_addr_i == (i < 16 ? `VIC_OFS_SRC_LO : `VIC_OFS_SRC_HI)) rdata[2*(i%16) +: 2] = src_sel[i];
            if (reg_addr_i == vic_ofs_t'(`VIC_OFS_PRIO0 + 4*(i/8))) rdata[4*(i%8) +: 3] = prio[i];
            if (reg_addr_i == vic_ofs_t'(`VIC_OFS_VECT0 + 4*i)) rdata[15:0] = vect[i];
        end
        case (reg_addr_i)
            `VIC_OFS_ENABLE:   rdata = enable;
            `VIC_OFS_SET_PENDING_FLAG: rdata = pending_flag;
            `VIC_OFS_CLR_PENDING_FLAG: rdata = posted_flag;
            `VIC_OFS_STATUS: begin
                rdata[`VIC_STAT_LVL_LSB +: 4]   = active_lvl;
                rdata[`VIC_STAT_DEPTH_LSB +: 4] = depth;
                rdata[`VIC_STAT_BUSY_BIT]       = (state != ST_IDLE);
            end
            default: ;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rdata : '0;
        end
    end

    assign link.irq              = irq_q;
    assign link.irq_num          = num_q;
    assign link.isr_addr         = addr_q;
    assign link.handler_complete = done_q;
endmodule // vic_ctrl

// ===== core/vic_cpu.sv
/*
 * Core-side end of the interrupt link: takes requests at instruction
 * boundaries, acknowledges, keeps a return-address stack.
 * Assumes the user side marks instruction ends and handler returns with pulses.
 */
`timescale 1ns/1ns
`include "vic_params.svh"

module vic_cpu (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              ce_i,
    input  wire vic_pkg::vic_addr_t pc_i,
    input  wire logic              instr_done_i,
    input  wire logic              return_from_interrupt_i,
    output logic                   branch_o,
    output vic_pkg::vic_addr_t     branch_addr_o,
    output vic_pkg::vic_num_t      vec_num_o,
    output logic                   resume_o,
    output vic_pkg::vic_addr_t     resume_addr_o,
    vic_if.cpu                     link
);
    import vic_pkg::*;

    vic_addr_t  pc_stack [`VIC_NUM_LVL];
    logic [3:0] sp;
    logic       ack;
    logic [2:0] ack_cnt;
    logic       return_from_interrupt_q;

    // acknowledge held seven cycles, address read in the first
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack           <= 1'b0;
            ack_cnt       <= 3'h0;
            branch_o      <= 1'b0;
            branch_addr_o <= '0;
            vec_num_o     <= '0;
        end else if (ce_i) begin
            branch_o <= 1'b0;
            if (!ack && link.irq && instr_done_i && sp < 4'(`VIC_NUM_LVL)) begin
                ack       <= 1'b1;
                ack_cnt   <= 3'(`VIC_ACK_CYCLES - 1);
                vec_num_o <= link.irq_num;
            end else if (ack) begin
                if (ack_cnt == 3'(`VIC_ACK_CYCLES - 1)) begin
                    branch_addr_o <= link.isr_addr;
                end
                if (ack_cnt == 3'h1) begin
                    branch_o <= 1'b1;
                end
                if (ack_cnt == 3'h0) begin
                    ack <= 1'b0;
                end
                ack_cnt <= ack_cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp            <= 4'h0;
            return_from_interrupt_q        <= 1'b0;
            resume_o      <= 1'b0;
            resume_addr_o <= '0;
            for (int i = 0; i < `VIC_NUM_LVL; i++) begin
                pc_stack[i] <= '0;
            end
        end else if (ce_i) begin
            return_from_interrupt_q   <= 1'b0;
            resume_o <= 1'b0;
            if (!ack && link.irq && instr_done_i && sp < 4'(`VIC_NUM_LVL)) begin
                pc_stack[sp[2:0]] <= pc_i + vic_addr_t'(1);
                sp                <= sp + 4'h1;
            end else if (return_from_interrupt_i && !ack && sp != 4'h0) begin
                resume_addr_o <= pc_stack[sp[2:0] - 3'h1];
                resume_o      <= 1'b1;
                return_from_interrupt_q        <= 1'b1;
                sp            <= sp - 4'h1;
            end
        end
    end

    assign link.core_irq_acknowledge  = ack;
    assign link.return_from_interrupt = return_from_interrupt_q;
endmodule // vic_cpu

// ===== sim/vic_link_asserts.sv
/*
 * Concurrent checks on the link between the interrupt controller and the core.
 * Assumes the testbench instantiates it beside the link interface, one clock.
 */
`timescale 1ns/1ns

module vic_link_asserts (
    input wire logic               clk_i,
    input wire logic               arst_n_i,
    input wire logic               irq,
    input wire vic_pkg::vic_num_t  irq_num,
    input wire vic_pkg::vic_addr_t isr_addr,
    input wire logic               core_irq_acknowledge,
    input wire logic               return_from_interrupt,
    input wire logic               handler_complete
);
    import vic_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    ack_hold_time_a: assert property ($rose(core_irq_acknowledge) |-> core_irq_acknowledge[*7] ##1 !core_irq_acknowledge)
        else $error("acknowledge not held for seven cycles");
    ack_after_irq_a: assert property ($rose(core_irq_acknowledge) |-> $past(irq))
        else $error("acknowledge without a request");
    irq_drop_a: assert property ($rose(core_irq_acknowledge) |=> !irq)
        else $error("request still up after acknowledge");
    vector_stable_a: assert property (irq && $past(irq) |-> $stable(irq_num) && $stable(isr_addr))
        else $error("vector changed while requesting");
    no_eval_ack_a: assert property (core_irq_acknowledge |-> !$rose(irq))
        else $error("new request during acknowledge");
    quiet_after_ack_a: assert property ($fell(core_irq_acknowledge) |-> !irq[*2])
        else $error("request sooner than evaluation allows");
    ret_to_done_a: assert property (return_from_interrupt |=> handler_complete)
        else $error("no completion after return");
    done_cause_a: assert property (handler_complete |-> $past(return_from_interrupt))
        else $error("completion without return");
    done_pulse_a: assert property (handler_complete |=> !handler_complete)
        else $error("completion longer than one cycle");

    cover property ($rose(core_irq_acknowledge));
    cover property (handler_complete);
    cover property ($rose(irq) && irq_num == 5'h1e);
endmodule // vic_link_asserts

// ===== sim/tb.sv
/*
 * Self-checking bench: controller and core joined by the link interface.
 * Assumes ce_i held high; instruction boundaries come at random cycles.
 */
`timescale 1ns/1ns
`include "vic_params.svh"

module tb;
    import vic_pkg::*;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, return_from_interrupt_i = 1'b0;
    vic_vec_t    fixed_req_i = '0, fabric_req_i = '0, en_sh = '0;
    logic [15:0] dma_term_out_low_i = 16'h0, dma_term_out_high_i = 16'h0, vaddr [32];
    vic_ofs_t    reg_addr_i = 8'h0;
    vic_word_t   reg_wdata_i = 32'h0, reg_rdata_o, d;
    vic_addr_t   pc_i = 16'h0, branch_addr_o, resume_addr_o, pcs [$];
    vic_num_t    vec_num_o;
    logic        branch_o, resume_o;
    logic        instr_done_i = 1'b1;
    logic [63:0] src_sh = '0;
    logic [127:0] prio_sh = {32{4'h7}};
    int          n_errors = 0, samples_checked = 0, cyc = 0, v;

    vic_if link_if ();
    vic_ctrl vic_ctrl_inst (.clk_i, .arst_n_i, .ce_i(1'b1), .fixed_req_i, .dma_term_out_low_i,
        .dma_term_out_high_i, .fabric_req_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .link(link_if));
    vic_cpu vic_cpu_inst (.clk_i, .arst_n_i, .ce_i(1'b1), .pc_i, .instr_done_i, .return_from_interrupt_i, .branch_o,
        .branch_addr_o, .vec_num_o, .resume_o, .resume_addr_o, .link(link_if));
    vic_link_asserts vic_link_asserts_inst (.clk_i, .arst_n_i, .irq(link_if.irq), .irq_num(link_if.irq_num),
        .isr_addr(link_if.isr_addr), .core_irq_acknowledge(link_if.core_irq_acknowledge),
        .return_from_interrupt(link_if.return_from_interrupt), .handler_complete(link_if.handler_complete));

    always #10 clk_i = ~clk_i;

    always @(posedge clk_i) instr_done_i <= ($urandom_range(3) != 0);

    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The ceiling is far above the several hundred cycles the sequence needs.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input vic_ofs_t a, input vic_word_t w);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= w;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input vic_ofs_t a, output vic_word_t w);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 w = reg_rdata_o;
    endtask

    task automatic cfg(input int n, input logic [1:0] s, input logic [2:0] p, input logic en);
        src_sh[2*n +: 2] = s;
        prio_sh[4*n +: 4] = {1'b0, p};
        en_sh[n] = en;
        wr(`VIC_OFS_SRC_LO, src_sh[31:0]);
        wr(`VIC_OFS_SRC_HI, src_sh[63:32]);
        wr(`VIC_OFS_PRIO0 + vic_ofs_t'(4*(n/8)), prio_sh[32*(n/8) +: 32]);
        wr(`VIC_OFS_ENABLE, en_sh);
    endtask

    // the selected source line of the vector rises for one cycle.
    task automatic fire(input int n);
        @(posedge clk_i);
        case (src_sh[2*n +: 2])
            2'h0: fixed_req_i[n] <= 1'b1;
            2'h1: if (n < 16) dma_term_out_low_i[n] <= 1'b1; else dma_term_out_high_i[n-16] <= 1'b1;
            default: fabric_req_i[n] <= 1'b1;
        endcase
        @(posedge clk_i);
        fixed_req_i <= '0;
        fabric_req_i <= '0;
        dma_term_out_low_i <= 16'h0;
        dma_term_out_high_i <= 16'h0;
    endtask

    task automatic serve(input int n, input int lo, input int hi);
        int k = 0;
        @(posedge clk_i);
        pc_i <= 16'($urandom);
        do begin
            @(posedge clk_i);
            #1 k++;
        end while (link_if.irq !== 1'b1 && k < 40);
        pcs.push_back(pc_i + 16'h1);
        chk("irq latency", 1, k >= lo && k <= hi);
        chk("irq_num", n, link_if.irq_num);
        chk("isr_addr", vaddr[n], link_if.isr_addr);
        k = 0;
        do begin
            @(posedge clk_i);
            #1 k++;
        end while (branch_o !== 1'b1 && k < 20);
        chk("branch_addr_o", vaddr[n], branch_addr_o);
        chk("vec_num_o", n, vec_num_o);
    endtask

    task automatic ret();
        @(posedge clk_i);
        return_from_interrupt_i <= 1'b1;
        @(posedge clk_i);
        return_from_interrupt_i <= 1'b0;
        #1 chk("resume_o", 1, resume_o);
        chk("resume_addr_o", 32'(pcs.pop_back()), resume_addr_o);
    endtask

    // A wrongly raised request can be acked the cycle after it rises and drop one cycle later, so every cycle is watched.
    task automatic quiet(input string nm);
        int hits = 0;
        repeat (12) begin
            @(posedge clk_i);
            #1 if (link_if.irq !== 1'b0) hits++;
        end
        chk(nm, 0, hits);
    endtask

    initial begin
        v = $urandom(9902);
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(`VIC_OFS_ENABLE, d);
        chk("enable reset", 32'h0, d);
        rd(`VIC_OFS_PRIO0, d);
        chk("prio reset", 32'h7777_7777, d);
        rd(`VIC_OFS_SRC_HI, d);
        chk("source reset", 32'h0, d);
        rd(8'h40, d);
        chk("unmapped read", 32'h0, d);
        rd(`VIC_OFS_STATUS, d);
        chk("status reset", 32'h8, d);
        for (int n = 0; n < 32; n++) begin
            vaddr[n] = 16'($urandom);
            wr(`VIC_OFS_VECT0 + vic_ofs_t'(4*n), {16'h0, vaddr[n]});
        end
        for (int s = 0; s < 3; s++) begin
            for (int i = 0; i < 4; i++) begin
                do v = (s == 1 && i < 2) ? 15 + i : $urandom_range(31);
                while (s == 0 && !((`VIC_FIXED_USED >> v) & 32'h1));
                cfg(v, 2'(s), 3'($urandom_range(7)), 1'b1);
                fire(v);
                serve(v, 2, 5);
                ret();
            end
        end
        cfg(2, 2'h0, 3'h0, 1'b1);
        fire(2);
        quiet("reserved vector");
        // equal level: lower number first, no preemption.
        cfg(9, 2'h2, 3'h4, 1'b1);
        cfg(6, 2'h2, 3'h4, 1'b1);
        wr(`VIC_OFS_SET_PENDING_FLAG, 32'h0000_0240);
        serve(6, 0, 40);
        quiet("equal level preempt");
        ret();
        serve(9, 0, 40);
        ret();
        // disabled vector keeps its pending request.
        cfg(20, 2'h2, 3'h1, 1'b0);
        wr(`VIC_OFS_SET_PENDING_FLAG, 32'h0010_0000);
        quiet("disabled vector");
        cfg(20, 2'h2, 3'h1, 1'b1);
        serve(20, 0, 40);
        ret();
        // software clear of a pending request.
        cfg(21, 2'h2, 3'h1, 1'b0);
        wr(`VIC_OFS_SET_PENDING_FLAG, 32'h0020_0000);
        wr(`VIC_OFS_CLR_PENDING_FLAG, 32'h0020_0000);
        rd(`VIC_OFS_SET_PENDING_FLAG, d);
        chk("cleared pending", 0, d[21]);
        cfg(21, 2'h2, 3'h1, 1'b1);
        quiet("cleared vector");
        // nesting and restore of the active level.
        cfg(3, 2'h2, 3'h3, 1'b1);
        fire(3);
        serve(3, 2, 5);
        rd(`VIC_OFS_STATUS, d);
        chk("status one deep", 32'h13, d[7:0]);
        cfg(12, 2'h2, 3'h3, 1'b1);
        wr(`VIC_OFS_SET_PENDING_FLAG, 32'h0000_1000);
        quiet("same level nested");
        cfg(30, 2'h2, 3'h1, 1'b1);
        wr(`VIC_OFS_SET_PENDING_FLAG, 32'h4000_0000);
        serve(30, 0, 40);
        rd(`VIC_OFS_STATUS, d);
        chk("status two deep", 32'h21, d[7:0]);
        ret();
        rd(`VIC_OFS_STATUS, d);
        chk("status restored", 32'h13, d[7:0]);
        ret();
        serve(12, 0, 40);
        ret();
        rd(`VIC_OFS_STATUS, d);
        chk("status idle", 32'h08, d[7:0]);
        end_of_test();
    end
endmodule // tb
